// *** bench/dac_data_port_latch_sync_tb_top.sv ***
`default_nettype none

// Joins both link ends and checks the latched stream
module dac_data_port_latch_sync_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus and observed signals
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [1:0]  interp_sel = 2'h0;
  logic        word_valid;
  logic        word_ready = 1'b1;
  logic [15:0] word_data;
  logic [15:0] src_data = 16'h0000;
  logic        src_ready;
  logic        host_clk_drive = 1'b0;
  logic        follow_device = 1'b0;
  logic [7:0]  v;
  logic [15:0] w;
  int          seed = 6;
  int          bad_count = 0;
  int          num_checks = 0;
  int          wcnt = 0;
  int          cyc = 0;

  ddpls_link_if link ();
  ddpls_device_end ddpls_device_end_i (.clk_sys(clk_sys), .rst(rst),
    .link(link), .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .interp_sel(interp_sel),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
  ddpls_host_end ddpls_host_end_i (.clk_sys(clk_sys), .rst(rst),
    .link(link), .src_valid(1'b1), .src_ready(src_ready),
    .src_data(src_data), .host_clk_drive(host_clk_drive),
    .follow_device(follow_device), .interp_sel(interp_sel));
  ddpls_link_monitor ddpls_link_monitor_i (.clk_sys(clk_sys), .rst(rst),
    .conv_clk(link.conv_clk), .data_bus(link.data_bus),
    .host_drc_o(link.host_drc_o), .host_drc_oe_n(link.host_drc_oe_n),
    .dev_drc_o(link.dev_drc_o), .dev_drc_oe_n(link.dev_drc_oe_n),
    .drc_level(link.drc_level));

  // Clock
  always #50 clk_sys = ~clk_sys;

  // Random words, word counter, hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (src_ready === 1'b1) src_data <= 16'($random(seed));
    if (word_valid === 1'b1 && word_ready === 1'b1) wcnt <= wcnt + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // Words per 800 cycles: one per data rate period
  function automatic int exp_words(input logic [1:0] s);
    return 800 / (4 << s);
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    num_checks++;
    if (e !== s) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Counts words over a window; one word slack for phase
  task automatic rate(input int e);
    repeat (100) @(posedge clk_sys);
    #1 wcnt = 0;
    repeat (800) @(posedge clk_sys);
    #1 chk("word rate", 16'(e), 16'((wcnt >= e-1 && wcnt <= e+1) ? e : wcnt));
  endtask

  task automatic rst_pulse();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h02, v);
    chk("clock cfg reset", 16'h0000, {8'h00, v});
    rd(8'h05, v);
    chk("offset reset", 16'h0000, {8'h00, v});
    rd(8'h33, v);
    chk("unmapped read", 16'h0000, {8'h00, v});
    w = 16'($random(seed));
    wr(8'h05, {w[7:4], 4'h0});
    rd(8'h05, v);
    chk("offset readback", {8'h00, w[7:4], 4'h0}, {8'h00, v});
    wr(8'h12, 8'hff);
    rd(8'h12, v);
    chk("lock flags ext", 16'h0000, {13'h0, v[2:0]});
    // External sync, every factor, random offset ignored
    for (int s = 0; s < 4; s++) begin
      interp_sel <= 2'(s);
      wr(8'h05, {4'($random(seed)) & (s == 1 ? 4'hc : s == 2 ? 4'he : 4'hf),
                 4'h0});
      rate(exp_words(2'(s)));
    end
    wr(8'h02, 8'h10);
    rate(exp_words(interp_sel));
    // Receiver stalls: head word stands, overflow flagged
    word_ready <= 1'b0;
    repeat (200) @(posedge clk_sys);
    #1 w = word_data;
    repeat (200) @(posedge clk_sys);
    #1 chk("stalled word", w, word_data);
    rd(8'h12, v);
    chk("overflow set", 16'h0001, {15'h0, v[3]});
    word_ready <= 1'b1;
    rd(8'h12, v);
    rd(8'h12, v);
    chk("overflow clear", 16'h0000, {15'h0, v[3]});
    // Slave mode at 2x, both polarities
    interp_sel <= 2'h1;
    host_clk_drive <= 1'b1;
    rst_pulse();
    for (int p = 0; p < 2; p++) begin
      wr(8'h02, p[0] ? 8'h14 : 8'h04);
      rate(exp_words(2'h1));
      rd(8'h12, v);
      chk("lock flags", 16'h0007, {13'h0, v[2:0]});
    end
    // Low setup/hold latches on the rate clock
    wr(8'h02, 8'h00);
    wr(8'h05, 8'h08);
    rate(exp_words(2'h1));
    // Device drives the rate clock, source follows it
    host_clk_drive <= 1'b0;
    follow_device <= 1'b1;
    wr(8'h05, 8'h00);
    wr(8'h02, 8'h08);
    rate(exp_words(2'h1));
    summarize();
  end
endmodule

`default_nettype wire

// *** bench/ddpls_link_monitor.sv ***
`default_nettype none

// Watches the link pins between source and device
module ddpls_link_monitor (
  // Clock and reset
  input wire logic                         clk_sys,
  input wire logic                         rst,
  // Link pins
  input wire logic                         conv_clk,
  input wire logic [ddpls_pkg::WORD_W-1:0] data_bus,
  input wire logic                         host_drc_o,
  input wire logic                         host_drc_oe_n,
  input wire logic                         dev_drc_o,
  input wire logic                         dev_drc_oe_n,
  input wire logic                         drc_level
);
  // One domain for every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  conv_high_two_a: assert property (
    $rose(conv_clk) |=> conv_clk ##1 !conv_clk) else $error("conv high");
  conv_low_two_a: assert property (
    $fell(conv_clk) |=> !conv_clk ##1 conv_clk) else $error("conv low");
  data_hold_a: assert property (
    $changed(data_bus) |=> $stable(data_bus)[*3]) else $error("data hold");
  one_driver_a: assert property (
    dev_drc_oe_n || host_drc_oe_n) else $error("rate clock contention");
  dev_idle_low_a: assert property (
    dev_drc_oe_n |-> !dev_drc_o) else $error("device idle value");
  level_host_a: assert property (
    dev_drc_oe_n && !host_drc_oe_n |-> drc_level == host_drc_o)
    else $error("rate clock level");
  level_idle_a: assert property (
    dev_drc_oe_n && host_drc_oe_n |-> !drc_level) else $error("idle level");
  host_clk_hold_a: assert property (
    !host_drc_oe_n && $changed(host_drc_o) |=> $stable(host_drc_o))
    else $error("rate clock glitch");
endmodule

`default_nettype wire

// *** core/ddpls_device_end.sv ***
`default_nettype none

module ddpls_device_end (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // Link pins
  ddpls_link_if.dev                         link,
  // Register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_we,
  input  wire logic                         reg_re,
  input  wire logic [ddpls_pkg::REG_W-1:0]  reg_wdata,
  output logic [ddpls_pkg::REG_W-1:0]       reg_rdata,
  // Interpolation factor select
  input  wire logic [1:0]                   interp_sel,
  // Latched word stream
  output logic                              word_valid,
  input  wire logic                         word_ready,
  output logic [ddpls_pkg::WORD_W-1:0]      word_data
);

  localparam int SYNC_W = ddpls_pkg::WORD_W + 2; // Data, clock, clock

  // Pin synchronizer stages
  logic [SYNC_W-1:0]            meta_reg;     // First stage only
  logic [SYNC_W-1:0]            sync_reg;     // Second stage
  logic                         cc_prev_reg;  // Converter clock delayed
  logic                         drc_prev_reg; // Data rate clock delayed

  // Configuration registers
  logic [ddpls_pkg::REG_W-1:0]  clk_cfg_reg;  // data_clock_config
  logic [ddpls_pkg::REG_W-1:0]  off_cfg_reg;  // latch_offset_config

  // Phase and latch state
  logic [2:0]                   phase_reg;    // Converter rises mod N
  logic [2:0]                   phase_inc;    // Phase after a rise
  logic [2:0]                   target;       // Phase that latches
  logic [2:0]                   shift;        // Offset in cycles mod N
  logic [2:0]                   rel_phase;    // Phase minus offset
  logic [2:0]                   mask;         // N minus one
  logic [2:0]                   half;         // N over two
  logic                         latch_now;    // Latch pulse

  // Lock tracking
  logic [1:0]                   since_rise_reg; // Cycles after a rise
  logic                         seen_reg;     // Reference edge seen
  logic                         aligned_reg;  // Last edge well placed
  logic [2:0]                   lock_cnt_reg; // Aligned edges in a row
  logic                         overflow_reg; // Word lost, buffer full

  // Derived pin views
  logic                         cc_s;
  logic                         drc_s;
  logic [ddpls_pkg::WORD_W-1:0] data_s;
  logic                         cc_rise;
  logic                         cc_fall;
  logic                         drc_rise;
  logic                         drc_fall;
  logic                         ref_edge;
  logic                         edge_ok;
  logic                         pol;
  logic                         slave_like;
  logic [3:0]                   off;
  logic                         buf_in_ready;
  ddpls_pkg::ddpls_mode_type    mode;

  // Two stage synchronizer for clocks and data pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {link.drc_level, link.conv_clk, link.data_bus};
      sync_reg <= meta_reg;
    end
  end

  assign drc_s  = sync_reg[SYNC_W-1];
  assign cc_s   = sync_reg[SYNC_W-2];
  assign data_s = sync_reg[ddpls_pkg::WORD_W-1:0];

  // Edge detect delay stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cc_prev_reg  <= 1'b0;
      drc_prev_reg <= 1'b0;
    end else begin
      cc_prev_reg  <= cc_s;
      drc_prev_reg <= drc_s;
    end
  end

  assign cc_rise  = cc_s && !cc_prev_reg;
  assign cc_fall  = !cc_s && cc_prev_reg;
  assign drc_rise = drc_s && !drc_prev_reg;
  assign drc_fall = !drc_s && drc_prev_reg;

  // Configuration fields
  assign pol = clk_cfg_reg[ddpls_pkg::POS_LATCH_EDGE_POLARITY];
  assign off = off_cfg_reg[ddpls_pkg::POS_LATCH_EDGE_OFFSET_MSB:
                           ddpls_pkg::POS_LATCH_EDGE_OFFSET_LSB];
  assign ref_edge = pol ? drc_rise : drc_fall;

  always_comb begin
    unique case ({clk_cfg_reg[ddpls_pkg::POS_CLOCK_DIRECTION_SELECT],
                  off_cfg_reg[ddpls_pkg::POS_MODULATOR_SYNC_SELECT],
                  clk_cfg_reg[ddpls_pkg::POS_DATA_RECOVERY_SELECT]})
      3'b000:  mode = ddpls_pkg::DDPLS_MODE_EXT_SYNC;
      3'b001:  mode = ddpls_pkg::DDPLS_MODE_SLAVE;
      3'b010:  mode = ddpls_pkg::DDPLS_MODE_LOW_SH;
      3'b011:  mode = ddpls_pkg::DDPLS_MODE_MOD_SLAVE;
      default: mode = ddpls_pkg::DDPLS_MODE_MASTER;
    endcase
  end

  assign slave_like = (mode == ddpls_pkg::DDPLS_MODE_SLAVE) ||
                      (mode == ddpls_pkg::DDPLS_MODE_MOD_SLAVE);

  // Interpolation factor as mask and half period
  assign mask = {interp_sel == 2'b11, interp_sel[1], interp_sel != 2'b00};
  assign half = {interp_sel == 2'b11, interp_sel == 2'b10,
                 interp_sel == 2'b01};

  always_comb begin
    unique case (interp_sel)
      2'b01:   shift = {2'b00, off[2]};
      2'b10:   shift = off[3:1];
      2'b11:   shift = off[2:0];
      default: shift = 3'h0;
    endcase
  end

  assign phase_inc = (phase_reg + 3'h1) & mask;
  assign rel_phase = (phase_reg - shift) & mask;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= 3'h0;
    end else if (slave_like && ref_edge) begin
      phase_reg <= mask;
    end else if (cc_rise) begin
      phase_reg <= phase_inc;
    end
  end

  // Latching phase for each mode
  always_comb begin
    unique case (mode)
      ddpls_pkg::DDPLS_MODE_EXT_SYNC:  target = pol ? half : 3'h0;
      ddpls_pkg::DDPLS_MODE_MASTER:
        target = (mask + shift + (pol ? half - 3'h1 : mask)) & mask;
      ddpls_pkg::DDPLS_MODE_LOW_SH:    target = 3'h0;
      default:                         target = (mask + shift) & mask;
    endcase
  end

  // Latch pulse selection
  always_comb begin
    if (mode == ddpls_pkg::DDPLS_MODE_LOW_SH) begin
      latch_now = ref_edge;
    end else if (interp_sel == 2'b00 && !slave_like) begin
      latch_now = pol ? cc_rise : cc_fall;
    end else begin
      latch_now = cc_rise && (phase_inc == target);
    end
  end

  // Cycles since last converter rise, saturating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      since_rise_reg <= 2'h0;
    end else if (cc_rise) begin
      since_rise_reg <= 2'h0;
    end else if (since_rise_reg != 2'h3) begin
      since_rise_reg <= since_rise_reg + 2'h1;
    end
  end

  // edge too near a rise is misaligned
  assign edge_ok = (phase_reg == mask) &&
                   (since_rise_reg >= ddpls_pkg::SETUP_CYC) && !cc_rise;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen_reg     <= 1'b0;
      aligned_reg  <= 1'b0;
      lock_cnt_reg <= 3'h0;
    end else if (!slave_like) begin
      seen_reg     <= 1'b0;
      aligned_reg  <= 1'b0;
      lock_cnt_reg <= 3'h0;
    end else if (ref_edge) begin
      seen_reg    <= 1'b1;
      aligned_reg <= edge_ok;
      if (!edge_ok) begin
        lock_cnt_reg <= 3'h0;
      end else if (lock_cnt_reg != ddpls_pkg::LOCK_COUNT) begin
        lock_cnt_reg <= lock_cnt_reg + 3'h1;
      end
    end
  end

  // Lost word flag, set wins over read clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overflow_reg <= 1'b0;
    end else if (latch_now && !buf_in_ready) begin
      overflow_reg <= 1'b1;
    end else if (reg_re && reg_addr == ddpls_pkg::ADDR_DLL_LOCK_STATUS) begin
      overflow_reg <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_cfg_reg <= ddpls_pkg::RST_DATA_CLOCK_CONFIG;
      off_cfg_reg <= ddpls_pkg::RST_LATCH_OFFSET_CONFIG;
    end else if (reg_we) begin
      if (reg_addr == ddpls_pkg::ADDR_DATA_CLOCK_CONFIG) begin
        clk_cfg_reg <= reg_wdata;
      end
      if (reg_addr == ddpls_pkg::ADDR_LATCH_OFFSET_CONFIG) begin
        off_cfg_reg <= reg_wdata;
      end
    end
  end

  // Registered read data, unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        ddpls_pkg::ADDR_DATA_CLOCK_CONFIG:   reg_rdata <= clk_cfg_reg;
        ddpls_pkg::ADDR_LATCH_OFFSET_CONFIG: reg_rdata <= off_cfg_reg;
        ddpls_pkg::ADDR_DLL_LOCK_STATUS:
          reg_rdata <= {4'h0, overflow_reg,
                        lock_cnt_reg == ddpls_pkg::LOCK_COUNT,
                        aligned_reg, seen_reg};
        default:                             reg_rdata <= 8'h00;
      endcase
    end
  end

  // pin driven only in master mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.dev_drc_o    <= 1'b0;
      link.dev_drc_oe_n <= 1'b1;
    end else begin
      link.dev_drc_oe_n <= (mode != ddpls_pkg::DDPLS_MODE_MASTER);
      if (mode != ddpls_pkg::DDPLS_MODE_MASTER) begin
        link.dev_drc_o <= 1'b0;
      end else if (interp_sel == 2'b00) begin
        // 1x: inverted converter clock
        link.dev_drc_o <= !cc_s;
      end else begin
        // Low for first half after offset point
        link.dev_drc_o <= (rel_phase >= half);
      end
    end
  end

  // Latched words wait here for the consumer
  ddpls_skid2 u_word_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (latch_now),
    .in_ready  (buf_in_ready),
    .in_data   (data_s),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

endmodule

`default_nettype wire

// *** core/ddpls_host_end.sv ***
`default_nettype none

// Data source: makes converter clock, rate clock and words
module ddpls_host_end (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // Link pins
  ddpls_link_if.host                        link,
  // Word stream in
  input  wire logic                         src_valid,
  output logic                              src_ready,
  input  wire logic [ddpls_pkg::WORD_W-1:0] src_data,
  // Configuration
  input  wire logic                         host_clk_drive,
  input  wire logic                         follow_device,
  input  wire logic [1:0]                   interp_sel
);

  logic [3:0]                   div_reg;      // Half period counter
  logic [2:0]                   phase_reg;    // Converter rises mod N
  logic [2:0]                   phase_next;   // Phase after a rise
  logic [2:0]                   mask;         // N minus one
  logic [2:0]                   half;         // N over two
  logic                         tick;         // Converter clock toggles
  logic                         cc_rise_evt;  // Converter clock rises
  logic                         cc_fall_evt;  // Converter clock falls
  logic [1:0]                   drc_sync_reg; // Device clock sync
  logic                         drc_prev_reg; // Device clock delayed
  logic                         update;       // Present next word
  logic                         buf_valid;
  logic [ddpls_pkg::WORD_W-1:0] buf_data;

  assign mask = {interp_sel == 2'b11, interp_sel[1], interp_sel != 2'b00};
  assign half = {interp_sel == 2'b11, interp_sel == 2'b10,
                 interp_sel == 2'b01};
  assign tick = (div_reg == ddpls_pkg::CC_HALF_CYCLES - 4'h1);
  assign cc_rise_evt = tick && !link.conv_clk;
  assign cc_fall_evt = tick && link.conv_clk;
  assign phase_next = (phase_reg + 3'h1) & mask;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg       <= 4'h0;
      link.conv_clk <= 1'b0;
    end else if (tick) begin
      div_reg       <= 4'h0;
      link.conv_clk <= !link.conv_clk;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // Phase counter over converter rises
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= 3'h0;
    end else if (cc_rise_evt) begin
      phase_reg <= phase_next;
    end
  end

  // rate clock driven into a slave
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.host_drc_o    <= 1'b0;
      link.host_drc_oe_n <= 1'b1;
    end else begin
      link.host_drc_oe_n <= !(host_clk_drive && !follow_device);
      if (interp_sel == 2'b00 && tick) begin
        // 1x: inverted converter clock
        link.host_drc_o <= link.conv_clk;
      end else if (interp_sel != 2'b00 && cc_fall_evt) begin
        // edges mid cycle, clear of rises
        link.host_drc_o <= (phase_reg < half);
      end
    end
  end

  // Device rate clock sync for master mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drc_sync_reg <= 2'b00;
      drc_prev_reg <= 1'b0;
    end else begin
      drc_sync_reg <= {drc_sync_reg[0], link.drc_level};
      drc_prev_reg <= drc_sync_reg[1];
    end
  end

  // words change far from latch edge
  assign update = follow_device ? (drc_sync_reg[1] && !drc_prev_reg)
                                : (cc_rise_evt && phase_next == 3'h0);

  // Output word register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.data_bus <= 16'h0000;
    end else if (update && buf_valid) begin
      link.data_bus <= buf_data;
    end
  end

  // Incoming words held until their slot
  ddpls_skid2 u_src_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (buf_valid),
    .out_ready (update),
    .out_data  (buf_data)
  );

endmodule

`default_nettype wire

// *** core/ddpls_link_if.sv ***
`default_nettype none

// Pins between data source and converter data port
interface ddpls_link_if;
  logic                         conv_clk;     // Converter clock
  logic [ddpls_pkg::WORD_W-1:0] data_bus;     // Input word pins
  logic                         host_drc_o;   // Source drive value
  logic                         host_drc_oe_n; // Source enable, low drives
  logic                         dev_drc_o;    // Device drive value
  logic                         dev_drc_oe_n; // Device enable, low drives
  logic                         drc_level;    // Resolved data rate clock

  // Device wins when it drives; idle line reads low
  assign drc_level = !dev_drc_oe_n  ? dev_drc_o  :
                     !host_drc_oe_n ? host_drc_o : 1'b0;

  // Device end
  modport dev (
    input  conv_clk,
    input  data_bus,
    input  drc_level,
    output dev_drc_o,
    output dev_drc_oe_n
  );

  // Source end
  modport host (
    output conv_clk,
    output data_bus,
    output host_drc_o,
    output host_drc_oe_n,
    input  drc_level
  );
endinterface

`default_nettype wire

// *** core/ddpls_pkg.sv ***
`default_nettype none

// Shared constants for the data port latch synchronizer
package ddpls_pkg;

  // Widths
  localparam int WORD_W = 16;                 // Input word width
  localparam int REG_W  = 8;                  // Register width

  // Register offsets
  localparam logic [7:0] ADDR_DATA_CLOCK_CONFIG  = 8'h02;
  localparam logic [7:0] ADDR_LATCH_OFFSET_CONFIG = 8'h05;
  localparam logic [7:0] ADDR_DLL_LOCK_STATUS    = 8'h12;

  // Field positions in data_clock_config
  localparam int POS_LATCH_EDGE_POLARITY    = 4;
  localparam int POS_CLOCK_DIRECTION_SELECT = 3;
  localparam int POS_DATA_RECOVERY_SELECT   = 2;

  // Field positions in latch_offset_config
  localparam int POS_LATCH_EDGE_OFFSET_MSB  = 7;
  localparam int POS_LATCH_EDGE_OFFSET_LSB  = 4;
  localparam int POS_MODULATOR_SYNC_SELECT  = 3;

  // Field positions in dll_lock_status
  localparam int POS_OVERFLOW_FLAG = 3;

  // Values after reset
  localparam logic [7:0] RST_DATA_CLOCK_CONFIG   = 8'h00;
  localparam logic [7:0] RST_LATCH_OFFSET_CONFIG = 8'h00;

  // Timing: system clock period and transition setup window
  localparam int CLK_PERIOD_PS        = 100000;
  localparam int SETUP_TRANSITION_PS  = 1500;
  localparam int KEEPOUT_START_PS     = 500;
  // Least time, rounded up, never below one cycle
  localparam int SETUP_CYC_RAW =
    (SETUP_TRANSITION_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] SETUP_CYC =
    (SETUP_CYC_RAW < 1) ? 2'h1 : 2'(SETUP_CYC_RAW);

  // Aligned reference edges needed before lock is reported
  localparam logic [2:0] LOCK_COUNT = 3'h4;

  // Host converter clock half period in system cycles
  localparam logic [3:0] CC_HALF_CYCLES = 4'h2;

  // Port mode decoded from direction, modulator sync, recovery
  typedef enum logic [2:0] {
    DDPLS_MODE_EXT_SYNC  = 3'b000,
    DDPLS_MODE_SLAVE     = 3'b001,
    DDPLS_MODE_LOW_SH    = 3'b010,
    DDPLS_MODE_MOD_SLAVE = 3'b011,
    DDPLS_MODE_MASTER    = 3'b100
  } ddpls_mode_type;

endpackage

`default_nettype wire

// *** core/ddpls_skid2.sv ***
`default_nettype none

// Two entry buffer, head entry drives the output directly
module ddpls_skid2 (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // Fill side
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [ddpls_pkg::WORD_W-1:0] in_data,
  // Drain side
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [ddpls_pkg::WORD_W-1:0]      out_data
);

  logic [ddpls_pkg::WORD_W-1:0] head_reg;     // Oldest word
  logic [ddpls_pkg::WORD_W-1:0] tail_reg;     // Second word
  logic [1:0]                   count_reg;    // Words held
  logic [1:0]                   count_next;   // Words after this edge
  logic                         push;         // Word accepted
  logic                         pop;          // Word drained

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // Occupancy update
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  // Count and registered handshake flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 2'h0;
      out_valid <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      count_reg <= count_next;
      out_valid <= (count_next != 2'h0);
      in_ready  <= (count_next != 2'h2);
    end
  end

  // Storage shifts toward the head on a drain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      head_reg <= 16'h0000;
      tail_reg <= 16'h0000;
    end else if (pop) begin
      // Head refills from tail or from the incoming word
      head_reg <= (count_reg == 2'h2) ? tail_reg : in_data;
      if (push) begin
        tail_reg <= in_data;
      end
    end else if (push) begin
      if (count_reg == 2'h0) begin
        head_reg <= in_data;
      end else begin
        tail_reg <= in_data;
      end
    end
  end

  assign out_data = head_reg;

endmodule

`default_nettype wire
